// ==== rtl/cbd_pkg.sv ====
// Shared constants and types for the processor status bus command decoder
package cbd_pkg;

  // Status line codes, ordered line2,line1,line0
  localparam logic [2:0] STAT_IRQ_ACK = 3'h0;
  localparam logic [2:0] STAT_IO_RD = 3'h1;
  localparam logic [2:0] STAT_IO_WR = 3'h2;
  localparam logic [2:0] STAT_HALT = 3'h3;
  localparam logic [2:0] STAT_CODE_RD = 3'h4;
  localparam logic [2:0] STAT_MEM_RD = 3'h5;
  localparam logic [2:0] STAT_MEM_WR = 3'h6;
  localparam logic [2:0] STAT_PASSIVE = 3'h7;

  // Reset values
  localparam logic CMD_IDLE_LVL = 1'b1;
  localparam logic OE_OFF_LVL = 1'b1;
  localparam logic [5:0] SYNC_RST_VAL = 6'h3c;

  // Bit positions inside the synchroniser word
  localparam int SYNC_STAT_LSB = 3;
  localparam int SYNC_GRANT_BIT = 2;
  localparam int SYNC_QUAL_BIT = 1;
  localparam int SYNC_STRAP_BIT = 0;

  // Bus grant to command enable timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int GRANT_MIN_NS = 110;
  localparam int GRANT_MAX_NS = 250;
  localparam int GRANT_DLY_CYC = (GRANT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GRANT_MAX_CYC = GRANT_MAX_NS / CLK_PERIOD_NS;
  localparam logic [3:0] GRANT_CNT_LAST = 4'(GRANT_DLY_CYC - 1);

  // Machine cycle sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ALE = 4'h2,
    ST_CMD = 4'h4,
    ST_HOLD = 4'h8
  } cbd_state_t;

endpackage : cbd_pkg

// ==== rtl/cbd_sync.sv ====
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module cbd_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Data
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  logic [W-1:0] meta_ff;

  // First stage feeds only the second stage
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_ff <= RST_VAL;
      q_out <= RST_VAL;
    end else begin
      meta_ff <= d_in;
      q_out <= meta_ff;
    end
  end

endmodule : cbd_sync
`default_nettype wire

// ==== rtl/cbd_top.sv ====
// Status decoder, command strobes and transceiver control
// Functional notes
// (R1) Status code selects irq ack, io read/write, halt, memory read/write or passive.
// (R2) Every command output is active low.
// (R3) Early writes assert with read timing, before the normal write.
// (R4) Irq ack acts like an io read so the device drives its vector.
// (R5) Strap high keeps io and irq ack outputs enabled regardless of grant.
// (R6) Strap high: io commands start without wait, using periph enable and direction.
// (R7) Strap high: memory commands wait for bus grant low.
// (R8) Strap low: no command at all until a delay after grant low.
// (R9) Gated commands enable 110 to 250 ns after grant; tristate when grant high.
// (R10) Dual output: cascade gate high in system mode, periph enable low in io mode.
// (R11) Strap high: periph enable drives the io bus transceiver.
// (R12) System mode: cascade gate during irq ack sequences of two cycles.
// (R13) Outside logic masks the cascade gate in the first ack cycle.
// (R14) Cascade address gated before the second ack cycle, captured by latch strobe.
// (R15) With one interrupt controller the cascade gate stays unused outside.
// (R16) Latch strobe pulses every machine cycle and also captures status for halt.
// (R17) Data enable connects the buses; direction picks transfer direction.
// (R18) Direction high for writes, low for reads.
// (R19) All commands high while status is passive.
// (R20) Qualifier low forces commands and data enables inactive, still driven.
// (R21) Status registered; leaving passive starts a new machine cycle.
`timescale 1ns/1ns
`default_nettype none
module cbd_top
  import cbd_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Processor status lines
  input wire logic status_line0_in,
  input wire logic status_line1_in,
  input wire logic status_line2_in,
  // Arbitration, qualifier and strap
  input wire logic bus_grant_n_in,
  input wire logic command_qualifier_in,
  input wire logic io_bus_strap_in,
  // Command strobes, active low
  output logic mem_read_cmd_n_out,
  output logic mem_write_cmd_n_out,
  output logic early_mem_write_cmd_n_out,
  output logic io_read_cmd_n_out,
  output logic io_write_cmd_n_out,
  output logic early_io_write_cmd_n_out,
  output logic irq_ack_cmd_n_out,
  // Command output enables, low while driving
  output logic mem_cmd_oe_n_out,
  output logic io_cmd_oe_n_out,
  // Control outputs
  output logic address_latch_out,
  output logic data_xcvr_enable_out,
  output logic data_direction_out,
  output logic dual_function_output_out,
  output logic halt_state_out
);

  logic [5:0] sync_q;
  logic [2:0] stat_s;
  logic grant_n_s;
  logic qual_s;
  logic strap_s;
  cbd_state_t state_ff;
  logic [2:0] cyc_code_ff;
  logic [3:0] grant_cnt_ff;
  logic granted_ff;
  logic is_irq_ack;
  logic is_io_rd;
  logic is_io_wr;
  logic is_mem_rd;
  logic is_mem_wr;
  logic is_write;
  logic io_cycle;
  logic rd_phase;
  logic wr_phase;
  logic mem_ok;
  logic io_ok;
  logic nxt_mem_rd_n;
  logic nxt_mem_wr_n;
  logic nxt_early_mem_wr_n;
  logic nxt_io_rd_n;
  logic nxt_io_wr_n;
  logic nxt_early_io_wr_n;
  logic nxt_irq_ack_n;
  logic nxt_den;
  logic nxt_periph_en_n;
  logic nxt_cascade;

  // Pin inputs pass two flip-flops
  cbd_sync #(
    .W(6),
    .RST_VAL(SYNC_RST_VAL)
  ) u_sync (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .d_in({status_line2_in, status_line1_in, status_line0_in,
           bus_grant_n_in, command_qualifier_in, io_bus_strap_in}),
    .q_out(sync_q)
  );

  // Split the synchronised word
  assign stat_s = sync_q[SYNC_STAT_LSB +: 3];
  assign grant_n_s = sync_q[SYNC_GRANT_BIT];
  assign qual_s = sync_q[SYNC_QUAL_BIT];
  assign strap_s = sync_q[SYNC_STRAP_BIT];

  // (R21) Machine cycle sequencer
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= ST_IDLE;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (stat_s != STAT_PASSIVE) begin
            state_ff <= ST_ALE;
          end
        end
        ST_ALE: begin
          state_ff <= ST_CMD;
        end
        ST_CMD: begin
          state_ff <= (stat_s == STAT_PASSIVE) ? ST_IDLE : ST_HOLD;
        end
        ST_HOLD: begin
          if (stat_s == STAT_PASSIVE) begin
            state_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // (R21) Capture status code at cycle start
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cyc_code_ff <= STAT_PASSIVE;
    end else if (state_ff == ST_IDLE && stat_s != STAT_PASSIVE) begin
      cyc_code_ff <= stat_s;
    end
  end

  // (R9) Grant delay counter, drop at once on release
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      grant_cnt_ff <= 4'h0;
      granted_ff <= 1'b0;
    end else if (grant_n_s) begin
      grant_cnt_ff <= 4'h0;
      granted_ff <= 1'b0;
    end else if (grant_cnt_ff == GRANT_CNT_LAST) begin
      granted_ff <= 1'b1;
    end else begin
      grant_cnt_ff <= grant_cnt_ff + 4'h1;
    end
  end

  // (R1) Decode the captured status code
  assign is_irq_ack = (cyc_code_ff == STAT_IRQ_ACK);
  assign is_io_rd = (cyc_code_ff == STAT_IO_RD);
  assign is_io_wr = (cyc_code_ff == STAT_IO_WR);
  assign is_mem_rd = (cyc_code_ff == STAT_MEM_RD) || (cyc_code_ff == STAT_CODE_RD);
  assign is_mem_wr = (cyc_code_ff == STAT_MEM_WR);
  assign is_write = is_io_wr || is_mem_wr;
  // (R4) Irq ack counts as an io read cycle
  assign io_cycle = is_io_rd || is_io_wr || is_irq_ack;

  // (R3) Read-timed phase precedes the normal write phase
  assign rd_phase = (state_ff == ST_CMD) || (state_ff == ST_HOLD);
  assign wr_phase = (state_ff == ST_HOLD);

  // (R7) (R8) Memory always waits for grant
  assign mem_ok = granted_ff && qual_s;
  // (R5) (R6) Io bypasses grant when strapped high
  assign io_ok = (strap_s || granted_ff) && qual_s;

  // (R2) (R19) (R20) Active low strobes, high when idle or unqualified
  always_comb begin
    nxt_mem_rd_n = !(rd_phase && is_mem_rd && mem_ok);
    nxt_early_mem_wr_n = !(rd_phase && is_mem_wr && mem_ok);
    nxt_mem_wr_n = !(wr_phase && is_mem_wr && mem_ok);
    nxt_io_rd_n = !(rd_phase && is_io_rd && io_ok);
    nxt_early_io_wr_n = !(rd_phase && is_io_wr && io_ok);
    nxt_io_wr_n = !(wr_phase && is_io_wr && io_ok);
    nxt_irq_ack_n = !(rd_phase && is_irq_ack && io_ok);
  end

  // Command strobe registers
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      mem_read_cmd_n_out <= CMD_IDLE_LVL;
      early_mem_write_cmd_n_out <= CMD_IDLE_LVL;
      mem_write_cmd_n_out <= CMD_IDLE_LVL;
      io_read_cmd_n_out <= CMD_IDLE_LVL;
      early_io_write_cmd_n_out <= CMD_IDLE_LVL;
      io_write_cmd_n_out <= CMD_IDLE_LVL;
      irq_ack_cmd_n_out <= CMD_IDLE_LVL;
    end else begin
      mem_read_cmd_n_out <= nxt_mem_rd_n;
      early_mem_write_cmd_n_out <= nxt_early_mem_wr_n;
      mem_write_cmd_n_out <= nxt_mem_wr_n;
      io_read_cmd_n_out <= nxt_io_rd_n;
      early_io_write_cmd_n_out <= nxt_early_io_wr_n;
      io_write_cmd_n_out <= nxt_io_wr_n;
      irq_ack_cmd_n_out <= nxt_irq_ack_n;
    end
  end

  // (R9) (R5) Output enables follow grant, io group kept on by strap
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      mem_cmd_oe_n_out <= OE_OFF_LVL;
      io_cmd_oe_n_out <= OE_OFF_LVL;
    end else begin
      mem_cmd_oe_n_out <= !granted_ff;
      io_cmd_oe_n_out <= !(strap_s || granted_ff);
    end
  end

  // (R16) Latch strobe once per machine cycle
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      address_latch_out <= 1'b0;
    end else begin
      address_latch_out <= (state_ff == ST_ALE);
    end
  end

  // (R16) Halt decoded from status captured at the strobe
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      halt_state_out <= 1'b0;
    end else if (state_ff == ST_ALE) begin
      halt_state_out <= (cyc_code_ff == STAT_HALT);
    end
  end

  // (R17) (R11) (R12) Transceiver enables and cascade gate
  always_comb begin
    nxt_den = rd_phase && qual_s && granted_ff && (is_write || is_mem_rd || io_cycle) &&
              !(strap_s && io_cycle);
    nxt_periph_en_n = !(rd_phase && qual_s && strap_s && io_cycle);
    nxt_cascade = !strap_s && is_irq_ack && (state_ff == ST_ALE);
  end

  // (R17) (R20) System data transceiver enable
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      data_xcvr_enable_out <= 1'b0;
    end else begin
      data_xcvr_enable_out <= nxt_den;
    end
  end

  // (R18) Direction high on writes through the whole cycle
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      data_direction_out <= 1'b0;
    end else begin
      data_direction_out <= (state_ff != ST_IDLE) && is_write;
    end
  end

  // (R10) (R14) Dual output selected by strap
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      dual_function_output_out <= 1'b0;
    end else begin
      dual_function_output_out <= strap_s ? nxt_periph_en_n : nxt_cascade;
    end
  end

  // Checks on the registered outputs
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  idle_cmds_high_a: assert property (state_ff == ST_IDLE |=> // (R19)
    mem_read_cmd_n_out && mem_write_cmd_n_out && early_mem_write_cmd_n_out && io_read_cmd_n_out &&
    io_write_cmd_n_out && early_io_write_cmd_n_out && irq_ack_cmd_n_out)
    else $error("command active while status passive");

  latch_pulse_a: assert property (state_ff == ST_IDLE && stat_s != STAT_PASSIVE |-> // (R16)
    ##2 address_latch_out ##1 !address_latch_out)
    else $error("latch strobe not a single pulse");

  early_write_a: assert property (!mem_write_cmd_n_out || !io_write_cmd_n_out |-> // (R3)
    (mem_write_cmd_n_out || !early_mem_write_cmd_n_out) && (io_write_cmd_n_out || !early_io_write_cmd_n_out))
    else $error("normal write without early write");

  grant_delay_a: assert property ($rose(granted_ff) |-> // (R9)
    $past(!grant_n_s, 1) && $past(!grant_n_s, 6))
    else $error("grant enable before delay");

  grant_drop_a: assert property (grant_n_s && !strap_s |=> !granted_ff ##1 // (R9)
    mem_cmd_oe_n_out && (io_cmd_oe_n_out || $past(strap_s)))
    else $error("outputs not released after grant");

  qualifier_off_a: assert property (!qual_s |=> mem_read_cmd_n_out && io_read_cmd_n_out && // (R20)
    irq_ack_cmd_n_out && mem_write_cmd_n_out && io_write_cmd_n_out && !data_xcvr_enable_out)
    else $error("command active with qualifier low");

  mem_wait_a: assert property (!granted_ff |=> mem_read_cmd_n_out && // (R7)
    early_mem_write_cmd_n_out && mem_write_cmd_n_out)
    else $error("memory command without grant");

  strap_io_on_a: assert property (strap_s |=> !io_cmd_oe_n_out) // (R5)
    else $error("io outputs disabled in io bus mode");

  direction_set_a: assert property (state_ff == ST_ALE |=> data_direction_out == $past(is_write)) // (R18)
    else $error("wrong transfer direction");

  cascade_gate_a: assert property (!strap_s && state_ff == ST_ALE && is_irq_ack |=> // (R12)
    dual_function_output_out && address_latch_out)
    else $error("cascade gate missing in ack cycle");

  read_cycle_c: cover property (!mem_read_cmd_n_out ##1 mem_read_cmd_n_out);
  ack_cascade_c: cover property (dual_function_output_out && !strap_s ##[1:4] !irq_ack_cmd_n_out);
  io_fast_c: cover property (strap_s && grant_n_s ##1 !io_write_cmd_n_out);

endmodule : cbd_top
`default_nettype wire

// ==== testbench/cbd_cpu_model.sv ====
// Processor status and bus arbiter model
`timescale 1ns/1ns
`default_nettype none
module cbd_cpu_model (
  // Clock
  input wire logic mclk_in,
  // Status pins and grant
  output logic status_line0_out,
  output logic status_line1_out,
  output logic status_line2_out,
  output logic bus_grant_n_out
);
  // Outside mask for the first ack of a pair
  logic ack_first = 1'b0;
  logic ack_pend = 1'b0;
  // Idle bus, no grant
  initial begin
    {status_line2_out, status_line1_out, status_line0_out} = 3'h7;
    bus_grant_n_out = 1'b1;
  end
  // Code changes just after an edge and stays stable
  task automatic drive_code(input logic [2:0] code);
    @(posedge mclk_in);
    #2;
    {status_line2_out, status_line1_out, status_line0_out} = code;
    if (code == 3'h0) begin
      ack_first = !ack_pend;
      ack_pend = !ack_pend;
    end else if (code != 3'h7) begin
      ack_first = 1'b0;
      ack_pend = 1'b0;
    end
  endtask : drive_code
  task automatic end_cycle();
    drive_code(3'h7);
    repeat (4) @(posedge mclk_in);
  endtask : end_cycle
  // Arbiter grant level
  task automatic set_grant(input logic grant_n);
    @(posedge mclk_in);
    #2;
    bus_grant_n_out = grant_n;
  endtask : set_grant
endmodule : cbd_cpu_model
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the status bus command decoder
`timescale 1ns/1ns
`default_nettype none
module tb;
  import cbd_pkg::*;
  logic mclk_in, rst_in, qual, strap, granted;
  wire logic s0, s1, s2, grant_n;
  logic mrd, mwr, amw, iord, iowr, aiow, irq_ack_cmd, mem_oe_n, io_oe_n;
  logic latch, data_xcvr_enable, dir, dual, halt;
  wire logic [6:0] cmd_v;
  int n_fail, samples_checked, seed;
  assign cmd_v = {mrd, mwr, amw, iord, iowr, aiow, irq_ack_cmd};
  cbd_cpu_model i_cpu (.mclk_in(mclk_in), .status_line0_out(s0), .status_line1_out(s1),
    .status_line2_out(s2), .bus_grant_n_out(grant_n));
  cbd_top i_dut (.mclk_in(mclk_in), .rst_in(rst_in), .status_line0_in(s0), .status_line1_in(s1),
    .status_line2_in(s2), .bus_grant_n_in(grant_n), .command_qualifier_in(qual),
    .io_bus_strap_in(strap), .mem_read_cmd_n_out(mrd), .mem_write_cmd_n_out(mwr),
    .early_mem_write_cmd_n_out(amw), .io_read_cmd_n_out(iord), .io_write_cmd_n_out(iowr),
    .early_io_write_cmd_n_out(aiow), .irq_ack_cmd_n_out(irq_ack_cmd), .mem_cmd_oe_n_out(mem_oe_n),
    .io_cmd_oe_n_out(io_oe_n), .address_latch_out(latch), .data_xcvr_enable_out(data_xcvr_enable),
    .data_direction_out(dir), .dual_function_output_out(dual), .halt_state_out(halt));
  // Clock, 20 ns period
  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end
  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  task automatic chk(input string name, input logic [6:0] exp, input logic [6:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      n_fail++;
    end
  endtask : chk
  // Strobe levels {mrd,mwr,amw,iord,iowr,aiow,irq_ack_cmd}; rd_only masks normal writes
  function automatic logic [6:0] exp_cmd(input logic [2:0] c, input logic rd_only,
                                         input logic mem_ok, input logic io_ok);
    logic [6:0] v;
    v = 7'h7f;
    case (c)
      3'h0: v[0] = ~io_ok;
      3'h1: v[3] = ~io_ok;
      3'h2: begin
        v[2] = ~io_ok | rd_only;
        v[1] = ~io_ok;
      end
      3'h4, 3'h5: v[6] = ~mem_ok;
      3'h6: begin
        v[5] = ~mem_ok | rd_only;
        v[4] = ~mem_ok;
      end
      default: v = 7'h7f;
    endcase
    return v;
  endfunction : exp_cmd
  // One machine cycle with checks on latch, direction and strobes
  task automatic do_cycle(input logic [2:0] code, input int hold);
    int w;
    logic mem_ok, io_ok;
    mem_ok = granted & qual;
    io_ok = (granted | strap) & qual;
    i_cpu.drive_code(code);
    w = 0;
    do begin
      @(posedge mclk_in);
      #1;
      w++;
    end while (latch !== 1'b1 && w < 12);
    chk("latch", 7'h1, {6'h0, latch});
    chk("direction", {6'h0, code == 3'h2 || code == 3'h6}, {6'h0, dir});
    if (!strap) chk("cascade", {6'h0, code == 3'h0}, {6'h0, dual});
    if (!strap && code == 3'h0) chk("mask cascade", {6'h0, !i_cpu.ack_first}, {6'h0, dual & ~i_cpu.ack_first});
    @(posedge mclk_in);
    #1;
    chk("latch pulse", 7'h0, {6'h0, latch});
    chk("early", exp_cmd(code, 1'b1, mem_ok, io_ok), cmd_v);
    @(posedge mclk_in);
    #1;
    chk("cmds", exp_cmd(code, 1'b0, mem_ok, io_ok), cmd_v);
    if (code == 3'h0 && !i_cpu.ack_first) chk("vector ack", {6'h0, ~io_ok}, {6'h0, irq_ack_cmd});
    if (code >= 3'h4) chk("den", {6'h0, mem_ok}, {6'h0, data_xcvr_enable});
    if (strap && code <= 3'h2) chk("periph", {6'h0, ~qual}, {6'h0, dual});
    repeat (hold) @(posedge mclk_in);
    i_cpu.end_cycle();
    repeat (2) @(posedge mclk_in);
    #1;
    chk("passive", 7'h7f, cmd_v);
    chk("halt", {6'h0, code == 3'h3}, {6'h0, halt});
  endtask : do_cycle
  // Reset, set mode, run corner and random cycles
  task automatic phase(input logic st, input logic gr, input logic q, input int rst_len);
    @(posedge mclk_in);
    #2;
    rst_in = 1'b1;
    strap = st;
    qual = q;
    granted = gr;
    i_cpu.set_grant(~gr);
    repeat (rst_len) @(posedge mclk_in);
    #2;
    rst_in = 1'b0;
    repeat (14) @(posedge mclk_in);
    #1;
    chk("mem oe", {6'h0, ~gr}, {6'h0, mem_oe_n});
    chk("io oe", {6'h0, ~(gr | st)}, {6'h0, io_oe_n});
    for (int c = 0; c < 7; c++) do_cycle(3'(c), 0);
    do_cycle(3'h0, 0);
    do_cycle(3'h0, 1);
    for (int i = 0; i < 8; i++) do_cycle(3'($unsigned($random(seed)) % 7), $unsigned($random(seed)) % 4);
  endtask : phase
  // Grant window in system mode
  task automatic grant_timing();
    i_cpu.set_grant(1'b1);
    repeat (5) @(posedge mclk_in);
    #1;
    chk("oe off", 7'h1, {6'h0, mem_oe_n});
    i_cpu.set_grant(1'b0);
    repeat (5) @(posedge mclk_in);
    #1;
    chk("oe early", 7'h1, {6'h0, mem_oe_n});
    repeat (7) @(posedge mclk_in);
    #1;
    chk("oe late", 7'h0, {6'h0, mem_oe_n});
  endtask : grant_timing
  initial begin
    rst_in = 1'b1;
    qual = 1'b0;
    strap = 1'b0;
    granted = 1'b0;
    n_fail = 0;
    samples_checked = 0;
    seed = 39991;
    phase(1'b0, 1'b1, 1'b1, 10);
    phase(1'b1, 1'b0, 1'b1, 3);
    phase(1'b0, 1'b0, 1'b1, 3);
    phase(1'b1, 1'b1, 1'b1, 3);
    phase(1'b1, 1'b1, 1'b0, 3);
    phase(1'b0, 1'b1, 1'b0, 3);
    grant_timing();
    conclude();
  end
  // Watchdog against a hang
  initial begin
    #200000;
    n_fail++;
    conclude();
  end
endmodule : tb
`default_nettype wire
